// *** srbs_map.vh ***
// Purpose: constants of the software reset and boot select block
// Assumes: 32-bit APB word per register, 200 MHz system clock
// Notes: definitions only
`ifndef SRBS_MAP_VH
`define SRBS_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SRBS_OFS_CTRL 8'h00
`define SRBS_OFS_ADDR 8'h04
`define SRBS_OFS_DATA 8'h08
`define SRBS_OFS_CMD 8'h0C
`define SRBS_OFS_STAT 8'h10
`define SRBS_OFS_MASK 8'h14
`define SRBS_OFS_BOOT 8'h18
`define SRBS_OFS_PART 8'h1C
// ----------------------------------------
// flash_program_control fields
// ----------------------------------------
`define SRBS_CTRL_EN 7
`define SRBS_CTRL_BOOT 6
`define SRBS_CTRL_SOFT_RESET_TRIGGER 5
`define SRBS_CTRL_FAIL 4
`define SRBS_CTRL_WT_MSB 2
`define SRBS_CTRL_RST 8'h00
// ----------------------------------------
// event bits of status and mask
// ----------------------------------------
`define SRBS_EV_W 5
`define SRBS_EV_DONE 0
`define SRBS_EV_FAIL 1
`define SRBS_EV_REFUSED 2
`define SRBS_EV_LDR_TMO 3
`define SRBS_EV_SOFT_RESET_TRIGGER 4
// ----------------------------------------
// flash commands and reset causes
// ----------------------------------------
`define SRBS_CMD_NONE 2'h0
`define SRBS_CAUSE_POR 2'h0
`define SRBS_CAUSE_PIN 2'h1
`define SRBS_CAUSE_WDT 2'h2
`define SRBS_CAUSE_SOFT 2'h3
// ----------------------------------------
// addresses and timing
// ----------------------------------------
`define SRBS_START_ADDR 16'h0000
`define SRBS_VEC_BASE 16'h0003
`define SRBS_CLK_MHZ 200
`define SRBS_POR_DELAY_MS 200
`define SRBS_HOLD_CYC 32
`define SRBS_LDR_WAIT_CYC 1000000
`endif

// *** srbs_stretch.v ***
// Purpose: loadable down counter that stretches a start pulse
// Assumes: synchronous start and clear
// Notes: busy while count is nonzero
`timescale 1ns/1ps
module srbs_stretch #(
   parameter W = 26
) (
   // clock and reset
   input wire i_clk,
   input wire i_reset,
   // control
   input wire i_start,
   input wire i_clear,
   input wire [W-1:0] i_count,
   // status
   output wire o_busy
);
   reg [W-1:0] cnt;

   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         cnt <= {W{1'b0}};
      end else if (i_clear) begin
         cnt <= {W{1'b0}};
      end else if (i_start) begin
         cnt <= i_count;
      end else if (cnt != {W{1'b0}}) begin
         cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign o_busy = (cnt != {W{1'b0}});
endmodule

// *** srbs_guard.v ***
// Purpose: out-of-space check for flash command addresses
// Assumes: partition bounds captured at power-up
// Notes: combinational
`timescale 1ns/1ps
module srbs_guard (
   // target and executor
   input wire [15:0] i_addr,
   input wire i_loader,
   // partition bounds
   input wire [15:0] i_user_top,
   input wire [15:0] i_loader_base,
   input wire [15:0] i_ldata_size,
   input wire i_ldata_en,
   // verdict
   output wire o_allowed
);
   wire [16:0] ldata_end;
   wire in_user;
   wire in_data;
   wire in_ldata;

   assign ldata_end = {1'b0, i_loader_base} + {1'b0, i_ldata_size};
   assign in_user = (i_addr < i_user_top);
   assign in_data = !in_user && (i_addr < i_loader_base);
   assign in_ldata = (i_addr >= i_loader_base) && ({1'b0, i_addr} < ldata_end);
   // loader may reach user code, nobody the loader code
   assign o_allowed = in_data | (i_loader & in_user) | (i_loader & i_ldata_en & in_ldata);
endmodule

// *** srbs_top.v ***
// Purpose: software reset, boot region select and flash command gate
// Assumes: all inputs synchronous to I_CLK; I_RESET is power-on reset
// Notes: APB slave, zero wait after setup, read-to-clear status
`timescale 1ns/1ps
`include "srbs_map.vh"

module srbs_top #(
   parameter CW = 26,
   parameter POR_CYC = `SRBS_POR_DELAY_MS * `SRBS_CLK_MHZ * 1000,
   parameter LDR_CYC = `SRBS_LDR_WAIT_CYC,
   parameter HOLD_CYC = `SRBS_HOLD_CYC
) (
   // clock and reset
   input wire I_CLK,
   input wire I_RESET,
   // apb slave
   input wire I_PSEL,
   input wire I_PENABLE,
   input wire I_PWRITE,
   input wire [7:0] I_PADDR,
   input wire [31:0] I_PWDATA,
   output reg [31:0] O_PRDATA,
   output reg O_PREADY,
   output reg O_PSLVERR,
   // reset sources and options
   input wire I_PIN_RESET,
   input wire I_WDT_RESET,
   input wire I_POR_DELAY_EN,
   // partition configuration
   input wire [15:0] I_USER_TOP,
   input wire [15:0] I_LOADER_BASE,
   input wire [15:0] I_LDATA_SIZE,
   input wire I_LDATA_EN,
   // flash command port
   output reg O_FLASH_REQ,
   output reg [1:0] O_FLASH_CMD,
   output reg [15:0] O_FLASH_ADDR,
   output reg [7:0] O_FLASH_WDATA,
   input wire I_FLASH_DONE,
   input wire I_FLASH_ERR,
   input wire [7:0] I_FLASH_RDATA,
   // cpu side
   output reg O_CPU_RESET,
   output reg O_START_LOADER,
   output reg [15:0] O_START_ADDR,
   output reg O_EXT_FETCH_EN,
   input wire [2:0] I_IRQ_NUM,
   output reg [15:0] O_VECTOR_ADDR,
   // interrupt
   output reg O_IRQ
);
   // ----------------------------------------
   // functions
   // ----------------------------------------
   function [15:0] vec_addr;
      input [2:0] n;
      begin
         vec_addr = `SRBS_VEC_BASE + {10'h000, n, 3'h0};
      end
   endfunction

   function hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg prog_en;
   reg boot_sel;
   reg [2:0] wait_cfg;
   reg soft_reset_trigger;
   reg cmd_fail;
   reg [15:0] addr_reg;
   reg [7:0] wdata_reg;
   reg [7:0] rdata_reg;
   reg busy;
   reg [`SRBS_EV_W-1:0] status;
   reg [`SRBS_EV_W-1:0] mask;
   reg [`SRBS_EV_W-1:0] rd_snap;
   reg por_pend;
   reg cold_boot;
   reg ldr_run;
   reg [1:0] cause;
   reg [15:0] user_top;
   reg [15:0] loader_base;
   reg [15:0] ldata_size;
   reg ldata_en;
   reg [31:0] rd_word;
   reg mapped;

   wire setup;
   wire wr_en;
   wire rd_en;
   wire hold_busy;
   wire por_busy;
   wire ldr_busy;
   wire rst_next;
   wire allowed;
   wire trig;
   wire accept;
   wire ev_done;
   wire ev_fail;
   wire ev_ref;
   wire ev_ltmo;
   wire sys_req;
   wire ldr_start;
   wire [`SRBS_EV_W-1:0] events;
   wire [`SRBS_EV_W-1:0] rd_clr;
   wire [7:0] ctrl_word;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   assign setup = I_PSEL & ~I_PENABLE;
   assign wr_en = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
   assign rd_en = I_PSEL & I_PENABLE & O_PREADY & ~I_PWRITE;

   assign ctrl_word = {prog_en, boot_sel, soft_reset_trigger, cmd_fail, 1'b0, wait_cfg};

   always @* begin
      rd_word = 32'h00000000;
      mapped = 1'b1;
      case (I_PADDR)
         `SRBS_OFS_CTRL: rd_word = {24'h000000, ctrl_word};
         `SRBS_OFS_ADDR: rd_word = {16'h0000, addr_reg};
         `SRBS_OFS_DATA: rd_word = {24'h000000, rdata_reg};
         `SRBS_OFS_CMD: rd_word = {31'h00000000, busy};
         `SRBS_OFS_STAT: rd_word = {27'h0000000, status};
         `SRBS_OFS_MASK: rd_word = {27'h0000000, mask};
         `SRBS_OFS_BOOT: rd_word = {ldata_size, 10'h000, ldata_en, cold_boot,
                                    ldr_run, cause, O_START_LOADER};
         `SRBS_OFS_PART: rd_word = {loader_base, user_top};
         default: mapped = 1'b0;
      endcase
   end

   always @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_PREADY <= 1'b0;
         O_PSLVERR <= 1'b0;
         O_PRDATA <= 32'h00000000;
         rd_snap <= {`SRBS_EV_W{1'b0}};
      end else begin
         O_PREADY <= setup;
         O_PSLVERR <= setup & ~mapped;
         if (setup && !I_PWRITE) begin
            O_PRDATA <= rd_word;
         end
         // only bits actually reported are cleared later
         if (setup && !I_PWRITE && hit(I_PADDR, `SRBS_OFS_STAT)) begin
            rd_snap <= status;
         end else if (setup) begin
            rd_snap <= {`SRBS_EV_W{1'b0}};
         end
      end
   end

   // ----------------------------------------
   // flash_program_control
   // ----------------------------------------
   always @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         prog_en <= 1'b0;
         boot_sel <= 1'b0;
         wait_cfg <= 3'h0;
         soft_reset_trigger <= 1'b0;
         mask <= {`SRBS_EV_W{1'b0}};
         addr_reg <= 16'h0000;
         wdata_reg <= 8'h00;
      end else begin
         soft_reset_trigger <= 1'b0;
         if (wr_en && hit(I_PADDR, `SRBS_OFS_CTRL)) begin
            prog_en <= I_PWDATA[`SRBS_CTRL_EN];
            boot_sel <= I_PWDATA[`SRBS_CTRL_BOOT];
            wait_cfg <= I_PWDATA[`SRBS_CTRL_WT_MSB:0];
            soft_reset_trigger <= I_PWDATA[`SRBS_CTRL_SOFT_RESET_TRIGGER];
         end else if (sys_req) begin
            prog_en <= 1'b0;
         end
         if (wr_en && hit(I_PADDR, `SRBS_OFS_MASK)) begin
            mask <= I_PWDATA[`SRBS_EV_W-1:0];
         end
         if (wr_en && hit(I_PADDR, `SRBS_OFS_ADDR)) begin
            addr_reg <= I_PWDATA[15:0];
         end
         if (wr_en && hit(I_PADDR, `SRBS_OFS_DATA)) begin
            wdata_reg <= I_PWDATA[7:0];
         end
      end
   end

   // ----------------------------------------
   // flash command gate
   // ----------------------------------------
   srbs_guard u_guard (
      .i_addr(addr_reg),
      .i_loader(O_START_LOADER),
      .i_user_top(user_top),
      .i_loader_base(loader_base),
      .i_ldata_size(ldata_size),
      .i_ldata_en(ldata_en),
      .o_allowed(allowed)
   );

   assign trig = wr_en & hit(I_PADDR, `SRBS_OFS_CMD) & ~busy & ~O_CPU_RESET &
                 (I_PWDATA[1:0] != `SRBS_CMD_NONE);
   assign accept = trig & prog_en & allowed;
   assign ev_ref = trig & ~accept;
   assign ev_done = busy & I_FLASH_DONE & ~I_FLASH_ERR;
   assign ev_fail = busy & I_FLASH_DONE & I_FLASH_ERR;

   always @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         busy <= 1'b0;
         cmd_fail <= 1'b0;
         rdata_reg <= 8'h00;
         O_FLASH_REQ <= 1'b0;
         O_FLASH_CMD <= `SRBS_CMD_NONE;
         O_FLASH_ADDR <= 16'h0000;
         O_FLASH_WDATA <= 8'h00;
      end else begin
         O_FLASH_REQ <= accept;
         if (accept) begin
            busy <= 1'b1;
            O_FLASH_CMD <= I_PWDATA[1:0];
            O_FLASH_ADDR <= addr_reg;
            O_FLASH_WDATA <= wdata_reg;
         end else if (busy && I_FLASH_DONE) begin
            busy <= 1'b0;
            rdata_reg <= I_FLASH_RDATA;
         end
         if (ev_fail || ev_ref) begin
            cmd_fail <= 1'b1;
         end else if (ev_done) begin
            cmd_fail <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // reset sources and boot region
   // ----------------------------------------
   assign sys_req = por_pend | I_PIN_RESET | I_WDT_RESET | soft_reset_trigger | ev_ltmo;

   srbs_stretch #(.W(CW)) u_hold (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_start(sys_req),
      .i_clear(1'b0),
      .i_count(HOLD_CYC[CW-1:0]),
      .o_busy(hold_busy)
   );

   srbs_stretch #(.W(CW)) u_por (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_start(por_pend & I_POR_DELAY_EN),
      .i_clear(1'b0),
      .i_count(POR_CYC[CW-1:0]),
      .o_busy(por_busy)
   );

   assign rst_next = hold_busy | por_busy;

   always @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         por_pend <= 1'b1;
         O_CPU_RESET <= 1'b1;
         O_START_LOADER <= 1'b1;
         cause <= `SRBS_CAUSE_POR;
         user_top <= 16'h0000;
         loader_base <= 16'h0000;
         ldata_size <= 16'h0000;
         ldata_en <= 1'b0;
      end else begin
         por_pend <= 1'b0;
         O_CPU_RESET <= rst_next | sys_req;
         if (por_pend) begin
            O_START_LOADER <= 1'b1;
            cause <= `SRBS_CAUSE_POR;
            user_top <= I_USER_TOP;
            loader_base <= I_LOADER_BASE;
            ldata_size <= I_LDATA_SIZE;
            ldata_en <= I_LDATA_EN;
         end else if (I_PIN_RESET) begin
            O_START_LOADER <= 1'b0;
            cause <= `SRBS_CAUSE_PIN;
         end else if (I_WDT_RESET) begin
            O_START_LOADER <= 1'b0;
            cause <= `SRBS_CAUSE_WDT;
         end else if (soft_reset_trigger) begin
            O_START_LOADER <= boot_sel;
            cause <= `SRBS_CAUSE_SOFT;
         end else if (ev_ltmo) begin
            O_START_LOADER <= 1'b0;
            cause <= `SRBS_CAUSE_SOFT;
         end
      end
   end

   // ----------------------------------------
   // cold boot loader watch
   // ----------------------------------------
   assign ldr_start = cold_boot & O_CPU_RESET & ~rst_next & ~sys_req & ~ldr_run;
   assign ev_ltmo = cold_boot & ldr_run & ~ldr_busy & ~O_CPU_RESET;

   srbs_stretch #(.W(CW)) u_ldr (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_start(ldr_start),
      .i_clear(accept),
      .i_count(LDR_CYC[CW-1:0]),
      .o_busy(ldr_busy)
   );

   always @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         cold_boot <= 1'b1;
         ldr_run <= 1'b0;
      end else begin
         if (por_pend) begin
            cold_boot <= 1'b1;
            ldr_run <= 1'b0;
         end else if (sys_req || accept) begin
            cold_boot <= 1'b0;
            ldr_run <= 1'b0;
         end else if (ldr_start) begin
            ldr_run <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // interrupt status
   // ----------------------------------------
   assign events = {soft_reset_trigger, ev_ltmo, ev_ref, ev_fail, ev_done};
   assign rd_clr = (rd_en && hit(I_PADDR, `SRBS_OFS_STAT)) ? rd_snap :
                   {`SRBS_EV_W{1'b0}};

   always @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         status <= {`SRBS_EV_W{1'b0}};
         O_IRQ <= 1'b0;
      end else begin
         // a new event beats the read clear
         status <= (status & ~rd_clr) | events;
         O_IRQ <= |(status & mask);
      end
   end

   // ----------------------------------------
   // fetch addresses
   // ----------------------------------------
   always @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_START_ADDR <= `SRBS_START_ADDR;
         O_EXT_FETCH_EN <= 1'b0;
         O_VECTOR_ADDR <= `SRBS_VEC_BASE;
      end else begin
         O_START_ADDR <= `SRBS_START_ADDR;
         O_EXT_FETCH_EN <= 1'b0;
         O_VECTOR_ADDR <= vec_addr(I_IRQ_NUM);
      end
   end
endmodule

// *** srbs_props.sv ***
// Purpose: concurrent checks on the reset and boot select block
// Assumes: one clock domain, I_RESET async active high
// Notes: bound to srbs_top below the module
`timescale 1ns/1ps
`include "srbs_map.vh"
module srbs_props #(
   parameter HOLD_CYC = 32
) (
   // clock and reset
   input wire I_CLK,
   input wire I_RESET,
   // apb
   input wire I_PSEL,
   input wire I_PENABLE,
   input wire I_PWRITE,
   input wire [7:0] I_PADDR,
   input wire [31:0] I_PWDATA,
   input wire O_PREADY,
   input wire O_PSLVERR,
   // reset sources and cpu side
   input wire I_PIN_RESET,
   input wire I_WDT_RESET,
   input wire I_POR_DELAY_EN,
   input wire O_FLASH_REQ,
   input wire O_CPU_RESET,
   input wire O_START_LOADER,
   input wire [15:0] O_START_ADDR,
   input wire O_EXT_FETCH_EN,
   input wire [2:0] I_IRQ_NUM,
   input wire [15:0] O_VECTOR_ADDR
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RESET);
   // ----------------------------------------
   // length of each cpu reset hold
   // ----------------------------------------
   logic [31:0] hold_cnt;
   always @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         hold_cnt <= 32'h0;
      end else if (O_CPU_RESET) begin
         hold_cnt <= hold_cnt + 32'h1;
      end else begin
         hold_cnt <= 32'h0;
      end
   end
   // command write taken outside cpu reset, one cycle late
   logic cmd_wr_q;
   always @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         cmd_wr_q <= 1'b0;
      end else begin
         cmd_wr_q <= I_PSEL && I_PENABLE && O_PREADY && I_PWRITE &&
                     I_PADDR == `SRBS_OFS_CMD && !O_CPU_RESET;
      end
   end
   // ----------------------------------------
   // sequences and assertions
   // ----------------------------------------
   sequence s_wr_at(logic [7:0] ofs);
      I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == ofs;
   endsequence
   sequence s_soft_wr;
      s_wr_at(`SRBS_OFS_CTRL) ##0 I_PWDATA[5];
   endsequence
   a_ready_pulse: assert property (I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY)
      else $error("ready not a single cycle after setup");
   a_err_unmapped: assert property (O_PREADY |-> O_PSLVERR ==
      (($past(I_PADDR) > 8'h1C) || (($past(I_PADDR) & 8'h03) != 8'h00)))
      else $error("slave error does not match address map");
   a_soft_boot: assert property (s_soft_wr |-> ##2 O_CPU_RESET && O_START_LOADER == $past(I_PWDATA[6], 2))
      else $error("soft reset or boot region wrong after control write");
   a_warm_user: assert property (I_PIN_RESET || I_WDT_RESET |=> O_CPU_RESET && !O_START_LOADER)
      else $error("pin or watchdog reset did not restart user code");
   a_hold_len: assert property ($fell(O_CPU_RESET) |-> I_POR_DELAY_EN || (hold_cnt >= HOLD_CYC && hold_cnt <= HOLD_CYC + 2))
      else $error("cpu reset hold length wrong");
   a_req_gate: assert property (O_FLASH_REQ |-> cmd_wr_q ##1 !O_FLASH_REQ)
      else $error("flash request without accepted command");
   a_fixed_start: assert property (O_START_ADDR == `SRBS_START_ADDR && !O_EXT_FETCH_EN)
      else $error("start address or external fetch wrong");
   a_vec_place: assert property (1'b1 |=> O_VECTOR_ADDR == `SRBS_VEC_BASE + {10'h0, $past(I_IRQ_NUM), 3'h0})
      else $error("vector address wrong");
endmodule
bind srbs_top srbs_props #(.HOLD_CYC(HOLD_CYC)) srbs_props_inst (.I_CLK, .I_RESET, .I_PSEL,
   .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PREADY, .O_PSLVERR, .I_PIN_RESET, .I_WDT_RESET,
   .I_POR_DELAY_EN, .O_FLASH_REQ, .O_CPU_RESET, .O_START_LOADER, .O_START_ADDR, .O_EXT_FETCH_EN,
   .I_IRQ_NUM, .O_VECTOR_ADDR);

// *** test_srbs_top.sv ***
// Purpose: directed bench for the reset and boot select block
// Assumes: power-on hold 50 and loader watch 100 cycles
// Notes: drive and sample bus at rising edge, levels at falling edge
`timescale 1ns/1ps
`include "srbs_map.vh"
module test_srbs_top;
   logic I_CLK = 0, I_RESET = 1, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0, err;
   logic I_PIN_RESET = 0, I_WDT_RESET = 0, I_POR_DELAY_EN = 0, I_FLASH_DONE = 0, I_FLASH_ERR = 0;
   logic [7:0] I_PADDR = 8'h00, I_FLASH_RDATA = 8'h5A;
   logic [31:0] I_PWDATA = 32'h0, rd;
   logic [15:0] I_USER_TOP = 16'h1000, I_LOADER_BASE = 16'h2000, I_LDATA_SIZE = 16'h0100;
   logic I_LDATA_EN = 1;
   logic [2:0] I_IRQ_NUM = 3'h0;
   wire [31:0] O_PRDATA;
   wire O_PREADY, O_PSLVERR, O_FLASH_REQ, O_CPU_RESET, O_START_LOADER, O_EXT_FETCH_EN, O_IRQ;
   wire [1:0] O_FLASH_CMD;
   wire [15:0] O_FLASH_ADDR, O_START_ADDR, O_VECTOR_ADDR;
   wire [7:0] O_FLASH_WDATA;
   int fails = 0, num_checks = 0, cyc = 0, req_cnt = 0;
   always #2.5 I_CLK = ~I_CLK;
   srbs_top #(.POR_CYC(50), .LDR_CYC(100)) srbs_top_inst (.I_CLK, .I_RESET, .I_PSEL, .I_PENABLE,
      .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR, .I_PIN_RESET, .I_WDT_RESET,
      .I_POR_DELAY_EN, .I_USER_TOP, .I_LOADER_BASE, .I_LDATA_SIZE, .I_LDATA_EN, .O_FLASH_REQ,
      .O_FLASH_CMD, .O_FLASH_ADDR, .O_FLASH_WDATA, .I_FLASH_DONE, .I_FLASH_ERR, .I_FLASH_RDATA,
      .O_CPU_RESET, .O_START_LOADER, .O_START_ADDR, .O_EXT_FETCH_EN, .I_IRQ_NUM, .O_VECTOR_ADDR,
      .O_IRQ);
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic end_of_test;
      if (fails == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      logic rdy;
      I_PSEL <= 1'b1;
      I_PENABLE <= 1'b0;
      I_PWRITE <= wr;
      I_PADDR <= a;
      I_PWDATA <= d;
      @(posedge I_CLK);
      I_PENABLE <= 1'b1;
      do begin
         @(posedge I_CLK);
         rdy = O_PREADY;
         rd = O_PRDATA;
         err = O_PSLVERR;
      end while (rdy !== 1'b1);
      chk(rdy, 1'b1);
      I_PSEL <= 1'b0;
      I_PENABLE <= 1'b0;
      @(posedge I_CLK);
   endtask
   task automatic wait_rst(input logic v);
      int n;
      n = 0;
      do begin
         @(negedge I_CLK);
         n++;
      end while (O_CPU_RESET !== v && n < 300);
      chk(O_CPU_RESET, v);
      @(posedge I_CLK);
   endtask
   task automatic cmd(input logic [15:0] a, input int req, input logic [31:0] fail);
      int r0;
      r0 = req_cnt;
      apb(1'b1, `SRBS_OFS_ADDR, {16'h0, a});
      apb(1'b1, `SRBS_OFS_CMD, 32'h2);
      chk(32'(req_cnt - r0), 32'(req));
      if (req != 0) begin
         chk({O_FLASH_CMD, O_FLASH_ADDR, O_FLASH_WDATA}, {2'h2, a, 8'hA5});
         I_FLASH_DONE <= 1'b1;
         I_FLASH_ERR <= (fail != 32'h0);
         @(posedge I_CLK);
         I_FLASH_DONE <= 1'b0;
         I_FLASH_ERR <= 1'b0;
         @(posedge I_CLK);
      end
      apb(1'b0, `SRBS_OFS_CTRL, 32'h0);
      chk(rd & 32'h10, fail);
   endtask
   always @(negedge I_CLK) begin
      if (O_FLASH_REQ === 1'b1) begin
         req_cnt++;
      end
   end
   always @(posedge I_CLK) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         $display("CHECK FAILED at %0t: timeout", $time);
         end_of_test;
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge I_CLK);
      @(negedge I_CLK);
      chk({O_CPU_RESET, O_START_LOADER}, 2'b11);
      @(posedge I_CLK);
      I_RESET <= 1'b0;
      apb(1'b0, `SRBS_OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      I_USER_TOP <= 16'h3000;
      wait_rst(1'b0);
      wait_rst(1'b1);
      chk(O_START_LOADER, 1'b0);
      apb(1'b0, `SRBS_OFS_STAT, 32'h0);
      chk(rd & 32'h8, 32'h8);
      apb(1'b0, `SRBS_OFS_BOOT, 32'h0);
      chk(rd, 32'h01000026);
      apb(1'b0, `SRBS_OFS_PART, 32'h0);
      chk(rd, 32'h20001000);
      wait_rst(1'b0);
      apb(1'b1, `SRBS_OFS_DATA, 32'hA5);
      apb(1'b1, `SRBS_OFS_CTRL, 32'h80);
      cmd(16'h0500, 0, 32'h10);
      cmd(16'h1800, 1, 32'h0);
      apb(1'b0, `SRBS_OFS_DATA, 32'h0);
      chk(rd, 32'h5A);
      cmd(16'h1800, 1, 32'h10);
      apb(1'b1, `SRBS_OFS_CTRL, 32'h0);
      cmd(16'h1800, 0, 32'h10);
      apb(1'b0, `SRBS_OFS_STAT, 32'h0);
      apb(1'b1, `SRBS_OFS_MASK, 32'h10);
      apb(1'b1, `SRBS_OFS_CTRL, 32'h60);
      @(negedge I_CLK);
      chk({O_CPU_RESET, O_START_LOADER}, 2'b11);
      @(negedge I_CLK);
      chk(O_IRQ, 1'b1);
      @(posedge I_CLK);
      apb(1'b0, `SRBS_OFS_CTRL, 32'h0);
      chk(rd & 32'hE0, 32'h40);
      apb(1'b0, `SRBS_OFS_STAT, 32'h0);
      chk(rd & 32'h10, 32'h10);
      @(negedge I_CLK);
      chk(O_IRQ, 1'b0);
      @(posedge I_CLK);
      apb(1'b1, `SRBS_OFS_MASK, 32'h0);
      wait_rst(1'b0);
      apb(1'b1, `SRBS_OFS_CTRL, 32'h80);
      cmd(16'h0500, 1, 32'h0);
      cmd(16'h2010, 1, 32'h0);
      cmd(16'h2200, 0, 32'h10);
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, `SRBS_OFS_CTRL, 32'h60);
         wait_rst(1'b0);
         if (k == 0) begin
            apb(1'b1, `SRBS_OFS_CTRL, 32'h20);
         end else begin
            I_PIN_RESET <= (k == 1);
            I_WDT_RESET <= (k == 2);
            @(posedge I_CLK);
            I_PIN_RESET <= 1'b0;
            I_WDT_RESET <= 1'b0;
         end
         @(negedge I_CLK);
         chk({O_CPU_RESET, O_START_LOADER, O_IRQ}, 3'b100);
         wait_rst(1'b0);
      end
      chk({O_START_ADDR, O_EXT_FETCH_EN}, 17'h00000);
      for (int k = 0; k < 8; k++) begin
         I_IRQ_NUM <= k[2:0];
         @(posedge I_CLK);
         @(negedge I_CLK);
         chk(O_VECTOR_ADDR, 16'h0003 + 16'(8 * k));
         @(posedge I_CLK);
      end
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1);
      I_POR_DELAY_EN <= 1'b1;
      I_RESET <= 1'b1;
      @(posedge I_CLK);
      I_RESET <= 1'b0;
      repeat (45) @(posedge I_CLK);
      @(negedge I_CLK);
      chk(O_CPU_RESET, 1'b1);
      wait_rst(1'b0);
      apb(1'b0, `SRBS_OFS_PART, 32'h0);
      chk(rd, 32'h20003000);
      end_of_test;
   end
endmodule
